// ===== dv/srs_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module srs_cpu_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic nmi_n,
   output logic nmi_taken
);
   // warning acts as an unmaskable interrupt once out of reset
   always_ff @(posedge clk) nmi_taken <= reset_n && !nmi_n;
endmodule
`default_nettype wire

// ===== dv/srs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module srs_monitor #(parameter logic [31:0] hold_cycles = 32'h14) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic supply_ok_n_in,
   input wire logic low_line_ok_n_in,
   input wire logic manual_reset_in_n,
   input wire logic reset_out_n,
   input wire logic reset_out,
   input wire logic low_line_warn_n
);
   // ========================================
   // cycles since the last raw trigger
   logic [31:0] quiet;
   wire logic trg = !supply_ok_n_in || !manual_reset_in_n;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) quiet <= 32'h0;
      else quiet <= trg ? 32'h0 : quiet + 32'h1;
   end
   sequence s_held; trg[*5]; endsequence
   a_out_inv: assert property (reset_out == !reset_out_n) else $error("inverse");
   a_supply_trip: assert property (!supply_ok_n_in |-> ##4 !reset_out_n) else $error("supply");
   a_manual_trip: assert property (!manual_reset_in_n |-> ##4 !reset_out_n) else $error("manual");
   a_held_low: assert property (s_held |-> !reset_out_n) else $error("held");
   a_hold_min: assert property ($fell(reset_out_n) |-> !reset_out_n[*8]) else $error("short");
   a_no_early: assert property ($rose(reset_out_n) |-> quiet >= hold_cycles) else $error("early");
   a_no_late: assert property (quiet == hold_cycles + 6 |-> reset_out_n) else $error("late");
   // two synchroniser stages plus the output flop: the warning shows the input sampled three edges back
   a_warn_sync: assert property (low_line_warn_n |-> $past(low_line_ok_n_in, 3)) else $error("warn");
endmodule
bind srs_supervisor srs_monitor #(.hold_cycles(hold_cycles)) srs_monitor_i (
   .mclk(mclk),
   .nrst(nrst),
   .supply_ok_n_in(supply_ok_n_in),
   .low_line_ok_n_in(low_line_ok_n_in),
   .manual_reset_in_n(manual_reset_in_n),
   .reset_out_n(reset_out_n),
   .reset_out(reset_out),
   .low_line_warn_n(low_line_warn_n)
);
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam logic [31:0] h = 32'h14;
   logic mclk = 1'b0, nrst = 1'b0, supply_ok_n_in = 1'b1, low_line_ok_n_in = 1'b1, manual_reset_in_n = 1'b1;
   logic reset_out_n, reset_out, low_line_warn_n, nmi_taken;
   int failures = 0, n_checks = 0, n;
   // ========================================
   // rows: {supply, low line, manual} inputs, then {reset_n, warn_n}
   logic [4:0] rows [4] = '{5'h1f, 5'h04, 5'h19, 5'h16};
   srs_supervisor #(.hold_cycles(h)) srs_supervisor_i (
      .mclk(mclk),
      .nrst(nrst),
      .supply_ok_n_in(supply_ok_n_in),
      .low_line_ok_n_in(low_line_ok_n_in),
      .manual_reset_in_n(manual_reset_in_n),
      .reset_out_n(reset_out_n),
      .reset_out(reset_out),
      .low_line_warn_n(low_line_warn_n)
   );
   srs_cpu_model srs_cpu_model_i (.clk(mclk), .reset_n(reset_out_n), .nmi_n(low_line_warn_n), .nmi_taken(nmi_taken));
   initial forever #50 mclk = ~mclk;
   task automatic chk(input string s, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %b saw %b", s, e, g);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // k one-cycle triggers 4 apart; a missed restart releases 4 cycles early
   task automatic pulse(input int k);
      repeat (k) begin
         manual_reset_in_n = 1'b0;
         tick(1);
         manual_reset_in_n = 1'b1;
         tick(3);
      end
      for (n = 0; reset_out_n !== 1'b1 && n < 100; n++) tick(1);
      chk("hold", 1'b1, n >= h && n <= h + 2);
      if (n == 100) summarize();
   endtask
   initial begin
      tick(5);
      nrst = 1'b1;
      for (int i = 0; i < 4; i++) begin
         {supply_ok_n_in, low_line_ok_n_in, manual_reset_in_n} = rows[i][4:2];
         tick(h + 8);
         chk("rst_n", rows[i][1], reset_out_n);
         chk("warn_n", rows[i][0], low_line_warn_n);
         chk("rst", !rows[i][1], reset_out);
         chk("nmi", rows[i][1] && !rows[i][0], nmi_taken);
      end
      pulse(1);
      pulse(2);
      // mid-run reset: outputs assert at once, then power-up gets a full hold again
      nrst = 1'b0;
      #1;
      chk("rst_n_async", 1'b0, reset_out_n);
      chk("rst_async", 1'b1, reset_out);
      chk("warn_async", 1'b0, low_line_warn_n);
      tick(5);
      nrst = 1'b1;
      for (n = 0; reset_out_n !== 1'b1 && n < 100; n++) tick(1);
      chk("rst_hold", 1'b1, n == h + 3);
      chk("rst_rel", 1'b0, reset_out);
      summarize();
   end
endmodule
`default_nettype wire

// ===== rtl/srs_pkg.sv
package srs_pkg;
   // ========================================
   // timing
   localparam int unsigned clk_hz = 10000000;
   // hold period in microseconds; 1400, 200000 and 1600000 are the offered values
   localparam int unsigned hold_us_a = 1400;
   localparam int unsigned hold_us_c = 200000;
   localparam int unsigned hold_us_d = 1600000;
   localparam int unsigned hold_us_default = hold_us_c;
   // least time rounds up to whole cycles
   localparam longint unsigned hold_cycles_default =
      (longint'(hold_us_default) * longint'(clk_hz) + 64'd999999) / 64'd1000000;
   localparam int unsigned cnt_w = 32;
   localparam int unsigned sync_stages = 2;
   // ========================================
   // comparator bundle
   typedef struct packed {
      logic supply_low_n;
      logic low_line_n;
      logic manual_n;
   } srs_cmp_t;
   localparam srs_cmp_t cmp_reset = '{supply_low_n: 1'b0, low_line_n: 1'b0, manual_n: 1'b0};
   typedef enum logic [1:0] {
      st_hold_trig,
      st_count,
      st_run
   } srs_state_t;
endpackage

// ===== rtl/srs_supervisor.sv
// Operation
// R1: reset output asserted while supply below reset trip threshold, any ramp or brownout.
// R2: manual reset input low asserts reset output.
// R3: reset stays asserted as long as any trigger is active.
// R4: after triggers release, reset held one more full hold period.
// R5: every trigger yields at least one full hold period of reset.
// R6: active-high output is exact inverse of active-low, same timing.
// R7: low-line warning low whenever supply below low-line threshold, before reset.
// R8: hold period is a fixed build parameter, e.g. 1.4ms, 200ms, 1600ms.
// R9: processor may use low-line warning as non-maskable interrupt.
// R10: hold counted in clock cycles, restarted by any active trigger.
// R11: comparator results pass a two-stage synchroniser before use.
`timescale 1ns/10ps
`default_nettype none
module srs_supervisor #(
   parameter logic [srs_pkg::cnt_w-1:0] hold_cycles = srs_pkg::cnt_w'(srs_pkg::hold_cycles_default) // [R8]
) (
   input wire logic mclk,
   input wire logic nrst,
   // comparator results, active low: supply below reset trip threshold
   input wire logic supply_ok_n_in,
   // active low: supply below low-line threshold
   input wire logic low_line_ok_n_in,
   // active low: manual_reset_in_n below manual_trip_threshold
   input wire logic manual_reset_in_n,
   output logic reset_out_n,
   output logic reset_out,
   output logic low_line_warn_n
);
   // ========================================
   // synchroniser
   srs_pkg::srs_cmp_t sync_a;
   srs_pkg::srs_cmp_t sync_b;
   wire srs_pkg::srs_cmp_t raw_cmp = '{supply_low_n: supply_ok_n_in, low_line_n: low_line_ok_n_in,
                                       manual_n: manual_reset_in_n};

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sync_a <= srs_pkg::cmp_reset;
         sync_b <= srs_pkg::cmp_reset;
      end else begin
         sync_a <= raw_cmp; // [R11]
         sync_b <= sync_a; // [R11]
      end
   end

   // ========================================
   // trigger decode
   // after reset the inputs read as asserted, so power-up always gets a full hold
   wire logic trig = !sync_b.supply_low_n || !sync_b.manual_n; // [R1] [R2]

   // ========================================
   // hold state machine
   srs_pkg::srs_state_t state;
   srs_pkg::srs_state_t next_state;
   logic [srs_pkg::cnt_w-1:0] cnt;
   logic [srs_pkg::cnt_w-1:0] next_cnt;
   wire logic cnt_done = (cnt >= hold_cycles - srs_pkg::cnt_w'(1));

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         srs_pkg::st_hold_trig: begin
            next_cnt = '0;
            if (!trig) begin
               next_state = srs_pkg::st_count;
            end
         end
         srs_pkg::st_count: begin
            if (trig) begin
               // restart: a short glitch still gets a whole period
               next_state = srs_pkg::st_hold_trig; // [R10] [R5]
               next_cnt = '0;
            end else if (cnt_done) begin
               next_state = srs_pkg::st_run; // [R4]
            end else begin
               next_cnt = cnt + srs_pkg::cnt_w'(1); // [R10]
            end
         end
         srs_pkg::st_run: begin
            if (trig) begin
               next_state = srs_pkg::st_hold_trig; // [R5]
               next_cnt = '0;
            end
         end
         default: begin
            next_state = srs_pkg::st_hold_trig;
            next_cnt = '0;
         end
      endcase
   end

   wire logic next_reset_n = (next_state == srs_pkg::st_run); // [R3] [R4]

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= srs_pkg::st_hold_trig;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // ========================================
   // outputs, all registered
   // both polarities come from the same next value so they never skew
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reset_out_n <= 1'b0;
         reset_out <= 1'b1;
         low_line_warn_n <= 1'b0;
      end else begin
         reset_out_n <= next_reset_n; // [R1] [R3]
         reset_out <= !next_reset_n; // [R6]
         // threshold lies above the reset trip, so this falls first; [R9] user is the processor
         low_line_warn_n <= sync_b.low_line_n; // [R7]
      end
   end
endmodule
`default_nettype wire
